/* File: common/tbsc_cfg.svh */
// Constants of the 10BASE-T status and control register bank.
// Assumes inclusion by bare name from every file that decodes the map.
`ifndef TBSC_CFG_SVH
`define TBSC_CFG_SVH

// Register indices; byte address is four times the index
`define TBSC_IDX_STATUS_CONTROL 8'h1A
`define TBSC_IDX_IRQ_STATUS     8'h30
`define TBSC_IDX_IRQ_MASK       8'h31
`define TBSC_IDX_PHY_STATUS     8'h32

// Field positions inside the status and control word; the last is in the PHY status word
`define TBSC_BIT_SERIAL         15
`define TBSC_SQUELCH_HI         11
`define TBSC_SQUELCH_LO         9
`define TBSC_BIT_ECHO_OFF       8
`define TBSC_BIT_LINK_PULSE_OFF 7
`define TBSC_BIT_FORCE_LINK     6
`define TBSC_BIT_POLARITY       4
`define TBSC_BIT_SQE_OFF        1
`define TBSC_BIT_JABBER_OFF     0
`define TBSC_BIT_PHY_STATUS_POL 12

// Reset value and writable bits of the status and control word
`define TBSC_SC_RESET           16'h0804
`define TBSC_SC_WRITE_MASK      16'hFFEF

// Interrupt status bit positions and width
`define TBSC_IRQ_POLARITY       0
`define TBSC_IRQ_LINK           1
`define TBSC_IRQ_WIDTH          2

// Cycles after reset release before the strap is taken
`define TBSC_STRAP_SETTLE       3'h5

`endif

/* File: common/tbsc_pkg.sv */
// Types shared by the register bank and its helpers.
// Assumes the constants header is compiled alongside.
`include "tbsc_cfg.svh"

package tbsc_pkg;

	// Whole state of the register bank top
	typedef struct packed {
		logic [15:0]                ctrl;        // Stored control bits
		logic                       polarity;    // Latched-high inversion flag
		logic                       pol_prev;    // Last synced polarity level
		logic                       link_prev;   // Last reported link level
		logic                       ack;         // Bus answer cycle
		logic [31:0]                rdata;       // Captured read word
		logic [`TBSC_IRQ_WIDTH-1:0] irq_status;  // Sticky events
		logic [`TBSC_IRQ_WIDTH-1:0] irq_mask;    // Interrupt enables
		logic [2:0]                 strap_cnt;   // Strap settle counter
		logic                       strap_done;  // Strap taken
	} tbsc_top_state_type;

endpackage

/* File: common/tbsc_ctl_if.sv */
// Control bundle from the register bank to the 10BASE-T path.
// Assumes one driver (the bank) and one reader (the path).
`timescale 1ns/1ps
`default_nettype none

interface tbsc_ctl_if;
	logic [15:0] cfg;          // Status and control word
	logic        speed_100;    // Port runs at 100M
	logic        full_duplex;  // Port runs full duplex
	logic        loopback;     // Basic-control loopback
	modport src (output cfg, output speed_100, output full_duplex, output loopback);
	modport dst (input cfg, input speed_100, input full_duplex, input loopback);
endinterface

`default_nettype wire

/* File: rtl/tbsc_sync.sv */
// Three-stage synchroniser with agreement filter for pin inputs.
// Assumes inputs are asynchronous to clock; output changes on agreement.
`timescale 1ns/1ps
`default_nettype none

module tbsc_sync #(
	parameter int WIDTH = 3
) (
	// Clock and reset
	input  wire logic             clock,
	input  wire logic             rst_b,
	// Pins and settled levels
	input  wire logic [WIDTH-1:0] pin_in,
	output logic      [WIDTH-1:0] level_out
);

	// Stages and filtered level
	typedef struct packed {
		logic [WIDTH-1:0] s1;   // Metastable stage, read by s2 only
		logic [WIDTH-1:0] s2;   // Second stage
		logic [WIDTH-1:0] s3;   // Third stage
		logic [WIDTH-1:0] lvl;  // Accepted level
	} tbsc_sync_state_type;

	tbsc_sync_state_type cur;
	tbsc_sync_state_type next_cur;

	// Shift and accept where stages two and three agree
	always_comb begin
		next_cur = cur;
		next_cur.s1 = pin_in;
		next_cur.s2 = cur.s1;
		next_cur.s3 = cur.s2;
		next_cur.lvl = (cur.s2 & cur.s3) | (cur.lvl & (cur.s2 | cur.s3));
	end

	// State register
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			cur <= '0;
		end else begin
			cur <= next_cur;
		end
	end

	assign level_out = cur.lvl;

endmodule

`default_nettype wire

/* File: rtl/tbsc_path.sv */
// 10BASE-T path controls steered by the status and control word.
// Assumes transmit and line data are on clock; outputs are registered.
`timescale 1ns/1ps
`default_nettype none
`include "tbsc_cfg.svh"

module tbsc_path #(
	parameter int DATA_W = 4
) (
	// Clock and reset
	input  wire logic              clock,
	input  wire logic              rst_b,
	// Control bundle
	tbsc_ctl_if.dst                ctl,
	// Transmit side and line receive side
	input  wire logic              tx_en,
	input  wire logic [DATA_W-1:0] tx_data,
	input  wire logic              line_rx_dv,
	input  wire logic [DATA_W-1:0] line_rx_data,
	input  wire logic              link_detect,
	// Path controls and receive data
	output logic                   rx_dv,
	output logic      [DATA_W-1:0] rx_data,
	output logic                   serial_mode,
	output logic      [2:0]        squelch_level,
	output logic                   link_pulse_tx_en,
	output logic                   link_good_10,
	output logic                   sqe_test_en,
	output logic                   jabber_guard_en
);

	// Registered path outputs
	typedef struct packed {
		logic              rx_dv;
		logic [DATA_W-1:0] rx_data;
		logic              serial;
		logic [2:0]        squelch;
		logic              lp_en;
		logic              link;
		logic              sqe;
		logic              jabber;
	} tbsc_path_state_type;

	tbsc_path_state_type cur;
	tbsc_path_state_type next_cur;
	logic                ten_half;  // 10M half duplex
	logic                echo;      // Transmit shows on receive

	// Output steering
	always_comb begin
		next_cur = cur;
		ten_half = !ctl.speed_100 && !ctl.full_duplex;
		// Echo only on 10M half duplex; loopback is independent
		echo = ctl.loopback || (ten_half && !ctl.cfg[`TBSC_BIT_ECHO_OFF]);
		next_cur.rx_dv = echo ? tx_en : line_rx_dv;
		next_cur.rx_data = echo ? tx_data : line_rx_data;
		next_cur.serial = !ctl.speed_100 && ctl.cfg[`TBSC_BIT_SERIAL];
		next_cur.squelch = ctl.cfg[`TBSC_SQUELCH_HI:`TBSC_SQUELCH_LO];
		next_cur.lp_en = !ctl.cfg[`TBSC_BIT_LINK_PULSE_OFF];
		next_cur.link = link_detect || ctl.cfg[`TBSC_BIT_FORCE_LINK];
		// Heartbeat never at 100M or full duplex
		next_cur.sqe = ten_half && !ctl.cfg[`TBSC_BIT_SQE_OFF];
		next_cur.jabber = !ctl.speed_100 && !ctl.cfg[`TBSC_BIT_JABBER_OFF];
	end

	// State register
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			cur <= '0;
		end else begin
			cur <= next_cur;
		end
	end

	assign rx_dv = cur.rx_dv;
	assign rx_data = cur.rx_data;
	assign serial_mode = cur.serial;
	assign squelch_level = cur.squelch;
	assign link_pulse_tx_en = cur.lp_en;
	assign link_good_10 = cur.link;
	assign sqe_test_en = cur.sqe;
	assign jabber_guard_en = cur.jabber;

endmodule

`default_nettype wire

/* File: rtl/tbsc_top.sv */
// Register bank for 10BASE-T status and control, with Avalon-MM slave.
// Assumes mode inputs are on clock; strap and analog detects are pins.
//
// Added by the designer: register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
`include "tbsc_cfg.svh"

module tbsc_top
	import tbsc_pkg::*;
#(
	parameter int DATA_W = 4
) (
	// Clock and reset
	input  wire logic              clock,
	input  wire logic              rst_b,
	// Avalon-MM slave, byte addressed
	input  wire logic [7:0]        avs_address,
	input  wire logic              avs_read,
	input  wire logic              avs_write,
	input  wire logic [31:0]       avs_writedata,
	input  wire logic [3:0]        avs_byteenable,
	output logic      [31:0]       avs_readdata,
	output logic                   avs_waitrequest,
	// Interrupt
	output logic                   irq,
	// Strap and analog detects, asynchronous
	input  wire logic              serial_strap,
	input  wire logic              polarity_inverted,
	input  wire logic              link_detect,
	// Port mode, on clock
	input  wire logic              speed_100,
	input  wire logic              full_duplex,
	input  wire logic              loopback,
	// Transmit and line receive data
	input  wire logic              tx_en,
	input  wire logic [DATA_W-1:0] tx_data,
	input  wire logic              line_rx_dv,
	input  wire logic [DATA_W-1:0] line_rx_data,
	// Receive data toward the MAC side
	output logic                   rx_dv,
	output logic      [DATA_W-1:0] rx_data,
	// Path controls
	output logic                   serial_net_if_select,
	output logic      [2:0]        squelch_level,
	output logic                   link_pulse_tx_en,
	output logic                   link_good_10,
	output logic                   sqe_test_en,
	output logic                   jabber_guard_en,
	// Polarity mirror for the status summary
	output logic                   phy_status_polarity
);

	// Register state and its next value
	tbsc_top_state_type cur;
	tbsc_top_state_type next_cur;

	// Settled pin levels
	logic [2:0] pin_level;     // Strap, polarity, link
	logic       strap_lvl;     // Settled strap
	logic       pol_lvl;       // Settled inversion detect
	logic       link_lvl;      // Settled link detect

	// Decode and access terms
	logic       req_new;       // Request seen, not yet answered
	logic       take_write;    // Write takes effect this edge
	logic       take_read;     // Read completes this edge
	logic       sc_read;       // Status and control read completes
	logic [15:0] wr_lanes;     // Bits selected by byte enables
	logic [15:0] sc_view;      // Readable status and control word
	logic [`TBSC_IRQ_WIDTH-1:0] irq_events; // Events this cycle
	logic [`TBSC_IRQ_WIDTH-1:0] irq_clear;  // Write-one clears

	// Path outputs before they leave the module
	logic       path_link;     // Reported 10M link

	// Control bundle toward the path
	tbsc_ctl_if ctl ();

	// Byte address hit on an aligned register index
	function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] idx);
		logic [9:0] byte_addr;
		byte_addr = {idx, 2'b00};
		addr_hit = (addr == byte_addr[7:0]) && (idx[7:6] == 2'b00);
	endfunction

	// Three-stage filter on every pin input
	tbsc_sync #(
		.WIDTH   (3)
	) u_sync (
		.clock     (clock),
		.rst_b     (rst_b),
		.pin_in    ({link_detect, polarity_inverted, serial_strap}),
		.level_out (pin_level)
	);

	assign strap_lvl = pin_level[0];
	assign pol_lvl = pin_level[1];
	assign link_lvl = pin_level[2];

	// Bundle the live control word and port mode
	assign ctl.cfg = cur.ctrl;
	assign ctl.speed_100 = speed_100;
	assign ctl.full_duplex = full_duplex;
	assign ctl.loopback = loopback;

	// 10BASE-T path steering
	tbsc_path #(
		.DATA_W  (DATA_W)
	) u_path (
		.clock            (clock),
		.rst_b            (rst_b),
		.ctl              (ctl),
		.tx_en            (tx_en),
		.tx_data          (tx_data),
		.line_rx_dv       (line_rx_dv),
		.line_rx_data     (line_rx_data),
		.link_detect      (link_lvl),
		.rx_dv            (rx_dv),
		.rx_data          (rx_data),
		.serial_mode      (serial_net_if_select),
		.squelch_level    (squelch_level),
		.link_pulse_tx_en (link_pulse_tx_en),
		.link_good_10     (path_link),
		.sqe_test_en      (sqe_test_en),
		.jabber_guard_en  (jabber_guard_en)
	);

	assign link_good_10 = path_link;

	// Bus timing: one wait cycle, then the answer cycle
	always_comb begin
		req_new = (avs_read || avs_write) && !cur.ack;
		take_write = cur.ack && avs_write;
		take_read = cur.ack && avs_read;
		sc_read = take_read && addr_hit(avs_address, `TBSC_IDX_STATUS_CONTROL);
	end

	// Waitrequest high for the first cycle of each request
	assign avs_waitrequest = req_new;
	assign avs_readdata = cur.rdata;

	// Byte lanes map onto the low half-word only
	always_comb begin
		wr_lanes = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
	end

	// Readable word with the live polarity flag in bit 4
	always_comb begin
		sc_view = cur.ctrl & `TBSC_SC_WRITE_MASK;
		sc_view[`TBSC_BIT_POLARITY] = cur.polarity;
	end

	// Events and write-one-to-clear mask
	always_comb begin
		irq_events = '0;
		// Each new inversion detection is one event
		irq_events[`TBSC_IRQ_POLARITY] = pol_lvl && !cur.pol_prev;
		// Any change of the reported link is one event
		irq_events[`TBSC_IRQ_LINK] = path_link != cur.link_prev;
		irq_clear = '0;
		if (take_write && addr_hit(avs_address, `TBSC_IDX_IRQ_STATUS) && avs_byteenable[0]) begin
			irq_clear = avs_writedata[`TBSC_IRQ_WIDTH-1:0];
		end
	end

	// Next register state
	always_comb begin
		next_cur = cur;
		next_cur.ack = req_new;
		next_cur.pol_prev = pol_lvl;
		next_cur.link_prev = path_link;

		// Strap taken once the filter has settled
		if (!cur.strap_done) begin
			next_cur.strap_cnt = cur.strap_cnt + 3'h1;
			if (cur.strap_cnt == `TBSC_STRAP_SETTLE) begin
				next_cur.ctrl[`TBSC_BIT_SERIAL] = strap_lvl;
				next_cur.strap_done = 1'b1;
				next_cur.strap_cnt = cur.strap_cnt;
			end
		end

		// Read word captured in the wait cycle
		if (req_new && avs_read) begin
			if (addr_hit(avs_address, `TBSC_IDX_STATUS_CONTROL)) begin
				next_cur.rdata = {16'h0000, sc_view};
			end else if (addr_hit(avs_address, `TBSC_IDX_IRQ_STATUS)) begin
				next_cur.rdata = {{(32-`TBSC_IRQ_WIDTH){1'b0}}, cur.irq_status};
			end else if (addr_hit(avs_address, `TBSC_IDX_IRQ_MASK)) begin
				next_cur.rdata = {{(32-`TBSC_IRQ_WIDTH){1'b0}}, cur.irq_mask};
			end else if (addr_hit(avs_address, `TBSC_IDX_PHY_STATUS)) begin
				// Mirror copy; reading here leaves the flag alone
				next_cur.rdata = 32'h0000_0000;
				next_cur.rdata[`TBSC_BIT_PHY_STATUS_POL] = cur.polarity;
			end else begin
				// Unmapped reads return zero
				next_cur.rdata = 32'h0000_0000;
			end
		end

		// Control writes; reserved bits kept as written, bit 4 read-only
		if (take_write && addr_hit(avs_address, `TBSC_IDX_STATUS_CONTROL)) begin
			next_cur.ctrl = (cur.ctrl & ~(wr_lanes & `TBSC_SC_WRITE_MASK))
				| (avs_writedata[15:0] & wr_lanes & `TBSC_SC_WRITE_MASK);
		end

		// Interrupt mask writes
		if (take_write && addr_hit(avs_address, `TBSC_IDX_IRQ_MASK) && avs_byteenable[0]) begin
			next_cur.irq_mask = avs_writedata[`TBSC_IRQ_WIDTH-1:0];
		end

		// Sticky events; a new event beats its clear
		next_cur.irq_status = (cur.irq_status & ~irq_clear) | irq_events;

		// Only a reported one is cleared, so a fresh detection survives
		if (sc_read && cur.rdata[`TBSC_BIT_POLARITY]) begin
			next_cur.polarity = 1'b0;
		end
		// Latched high while inversion is seen; set wins over clear
		if (pol_lvl) begin
			next_cur.polarity = 1'b1;
		end
	end

	// State register; flag starts clear, control at its reset word
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			cur <= '0;
			cur.ctrl <= `TBSC_SC_RESET;
			cur.polarity <= 1'b0;
		end else begin
			cur <= next_cur;
		end
	end

	// Level interrupt from any unmasked sticky bit
	assign irq = |(cur.irq_status & cur.irq_mask);

	// Mirror of the latched flag for the status summary
	assign phy_status_polarity = cur.polarity;

endmodule

`default_nettype wire

/* File: verif/tbsc_props.sv */
// Checker for the 10BASE-T status and control register bank.
// Assumes it is bound into tbsc_top and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none

module tbsc_props #(
	parameter int DATA_W = 4
) (
	// Clock and reset
	input wire logic              clock,
	input wire logic              rst_b,
	// Bus and mode inputs
	input wire logic              avs_read,
	input wire logic              avs_write,
	input wire logic [7:0]        avs_address,
	input wire logic              avs_waitrequest,
	input wire logic              speed_100,
	input wire logic              full_duplex,
	input wire logic              loopback,
	// Data inputs and receive outputs
	input wire logic              tx_en,
	input wire logic [DATA_W-1:0] tx_data,
	input wire logic              line_rx_dv,
	input wire logic [DATA_W-1:0] line_rx_data,
	input wire logic              rx_dv,
	input wire logic [DATA_W-1:0] rx_data,
	// Path controls
	input wire logic              serial_net_if_select,
	input wire logic [2:0]        squelch_level,
	input wire logic              link_pulse_tx_en,
	input wire logic              sqe_test_en,
	input wire logic              jabber_guard_en,
	input wire logic              phy_status_polarity
);
	// One domain, so one clock and one disable for all
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_b);

	// Exactly one wait cycle per access
	AST_WAIT_ONE: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("bus answer not in second cycle");
	// Squelch only moves two edges after a write, or just after reset
	AST_SQUELCH_HOLD: assert property ($stable(squelch_level) || $past(avs_write, 2) || !$past(rst_b, 2))
		else $error("squelch level moved without a write");
	// Link pulse enable likewise
	AST_PULSE_HOLD: assert property ($stable(link_pulse_tx_en) || $past(avs_write, 2) || !$past(rst_b, 2))
		else $error("link pulse enable moved without a write");
	// Heartbeat off at 100M or full duplex
	AST_SQE_OFF: assert property ($past(speed_100 || full_duplex) |-> !sqe_test_en)
		else $error("heartbeat enabled outside half duplex 10M");
	// Jabber guard belongs to 10M only
	AST_JABBER_10: assert property ($past(speed_100) |-> !jabber_guard_en)
		else $error("jabber guard on at 100M");
	// Serial select has no effect at 100M
	AST_SERIAL_10: assert property ($past(speed_100) |-> !serial_net_if_select)
		else $error("serial select on at 100M");
	// Basic-control loopback always returns transmit data
	AST_LOOPBACK: assert property ($past(loopback) |-> rx_dv == $past(tx_en) && rx_data == $past(tx_data))
		else $error("loopback did not return transmit data");
	// No echo at 100M or full duplex
	AST_NO_ECHO: assert property ($past(!loopback && (speed_100 || full_duplex))
		|-> rx_dv == $past(line_rx_dv) && rx_data == $past(line_rx_data))
		else $error("receive data not from line");
	// Polarity flag falls only at a taken read of the control word
	AST_POL_CLEAR: assert property ($fell(phy_status_polarity)
		|-> $past(avs_read && !avs_waitrequest && avs_address == 8'h68))
		else $error("polarity flag cleared without control read");
endmodule

bind tbsc_top tbsc_props #(.DATA_W(DATA_W)) u_props (.clock, .rst_b, .avs_read, .avs_write,
	.avs_address, .avs_waitrequest, .speed_100, .full_duplex, .loopback, .tx_en, .tx_data,
	.line_rx_dv, .line_rx_data, .rx_dv, .rx_data, .serial_net_if_select, .squelch_level,
	.link_pulse_tx_en, .sqe_test_en, .jabber_guard_en, .phy_status_polarity);

`default_nettype wire

/* File: verif/tb.sv */
// Self-checking bench for the register bank, over Avalon-MM.
// Assumes the design's default DATA_W of 4 and one 200 MHz clock.
`timescale 1ns/1ps
`default_nettype none

module tb
	import tbsc_pkg::*;
;
	// Inputs driven by the bench
	logic        clock, rst_b, avs_read, avs_write, serial_strap, polarity_inverted;
	logic        link_detect, speed_100, full_duplex, loopback, tx_en, line_rx_dv;
	logic [7:0]  avs_address;
	logic [31:0] avs_writedata;
	logic [3:0]  avs_byteenable, tx_data, line_rx_data;
	// Outputs watched
	logic [31:0] avs_readdata, rq;
	logic        avs_waitrequest, irq, rx_dv, serial_net_if_select, link_pulse_tx_en;
	logic        link_good_10, sqe_test_en, jabber_guard_en, phy_status_polarity;
	logic [3:0]  rx_data;
	logic [2:0]  squelch_level;
	int          n_fail, comparisons, cycles;

	tbsc_top dut (.clock, .rst_b, .avs_address, .avs_read, .avs_write, .avs_writedata,
		.avs_byteenable, .avs_readdata, .avs_waitrequest, .irq, .serial_strap,
		.polarity_inverted, .link_detect, .speed_100, .full_duplex, .loopback, .tx_en,
		.tx_data, .line_rx_dv, .line_rx_data, .rx_dv, .rx_data, .serial_net_if_select,
		.squelch_level, .link_pulse_tx_en, .link_good_10, .sqe_test_en, .jabber_guard_en,
		.phy_status_polarity);

	// 5 ns clock
	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end

	// Hang guard; the whole run needs well under a thousand cycles
	always @(posedge clock) begin
		cycles++;
		if (cycles == 5000) begin
			n_fail++;
			conclude();
		end
	end

	// Verdict and end of run
	task automatic conclude();
		$display("comparisons %0d n_fail %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// One comparison, four-state exact
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clock);
	endtask

	// One bus access, held until waitrequest is seen low; a spare edge follows
	task automatic bus(input logic wr, input logic [7:0] a, input logic [15:0] d);
		avs_address <= a;
		avs_writedata <= {16'h0000, d};
		avs_byteenable <= 4'hF;
		avs_read <= !wr;
		avs_write <= wr;
		do @(posedge clock); while (avs_waitrequest !== 1'b0);
		rq = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge clock);
	endtask

	// Reset, then wait out the strap settle count
	task automatic do_reset();
		rst_b <= 1'b0;
		cyc(2);
		rst_b <= 1'b1;
		cyc(10);
	endtask

	// Inversion seen long enough to pass the synchroniser
	task automatic pol_pulse();
		polarity_inverted <= 1'b1;
		cyc(8);
		polarity_inverted <= 1'b0;
		cyc(8);
	endtask

	initial begin
		{rst_b, avs_read, avs_write, serial_strap, polarity_inverted, link_detect} = '0;
		{speed_100, full_duplex, loopback, tx_en, line_rx_dv} = '0;
		{avs_address, avs_writedata, avs_byteenable, tx_data, line_rx_data} = '0;
		{n_fail, comparisons, cycles} = '0;
		@(posedge clock);
		do_reset();
		// Reset values
		bus(1'b0, 8'h68, 16'h0000);
		chk("ctrl reset", 32'h00000804, rq);
		chk("squelch reset", 32'h4, squelch_level);
		chk("pulse reset", 32'h1, link_pulse_tx_en);
		chk("jabber reset", 32'h1, jabber_guard_en);
		chk("sqe reset", 32'h1, sqe_test_en);
		// Every single-bit control set, squelch field to 3
		bus(1'b1, 8'h68, 16'h87C7);
		bus(1'b0, 8'h68, 16'h0000);
		chk("ctrl back", 32'h000087C7, rq);
		chk("serial on", 32'h1, serial_net_if_select);
		chk("squelch set", 32'h3, squelch_level);
		chk("pulse off", 32'h0, link_pulse_tx_en);
		chk("forced link", 32'h1, link_good_10);
		chk("sqe off", 32'h0, sqe_test_en);
		chk("jabber off", 32'h0, jabber_guard_en);
		// Echo disabled, then basic loopback, then 100M
		tx_en <= 1'b1;
		tx_data <= 4'hA;
		line_rx_data <= 4'h5;
		cyc(2);
		chk("echo off rx", 32'h5, rx_data);
		chk("echo off dv", 32'h0, rx_dv);
		loopback <= 1'b1;
		cyc(2);
		chk("loopback rx", 32'hA, rx_data);
		chk("loopback dv", 32'h1, rx_dv);
		loopback <= 1'b0;
		speed_100 <= 1'b1;
		cyc(2);
		chk("serial at 100M", 32'h0, serial_net_if_select);
		chk("rx at 100M", 32'h5, rx_data);
		// Read-only polarity bit, echo back on
		speed_100 <= 1'b0;
		bus(1'b1, 8'h68, 16'h0814);
		bus(1'b0, 8'h68, 16'h0000);
		chk("polarity ro", 32'h00000804, rq);
		chk("echo rx", 32'hA, rx_data);
		chk("sqe half 10M", 32'h1, sqe_test_en);
		chk("real link", 32'h0, link_good_10);
		full_duplex <= 1'b1;
		cyc(2);
		chk("sqe full", 32'h0, sqe_test_en);
		chk("rx full", 32'h5, rx_data);
		full_duplex <= 1'b0;
		// 100M with jabber and heartbeat bits clear, so only speed gates them
		speed_100 <= 1'b1;
		link_detect <= 1'b1;
		cyc(8);
		chk("detected link", 32'h1, link_good_10);
		chk("jabber at 100M", 32'h0, jabber_guard_en);
		chk("sqe at 100M", 32'h0, sqe_test_en);
		speed_100 <= 1'b0;
		link_detect <= 1'b0;
		cyc(8);
		// Polarity flag, mirror and interrupt
		bus(1'b1, 8'hC0, 16'h0003);
		bus(1'b1, 8'hC4, 16'h0001);
		chk("irq idle", 32'h0, irq);
		pol_pulse();
		chk("irq pol", 32'h1, irq);
		bus(1'b0, 8'hC8, 16'h0000);
		chk("mirror set", 32'h1000, rq & 32'h1000);
		bus(1'b0, 8'hC8, 16'h0000);
		chk("mirror kept", 32'h1000, rq & 32'h1000);
		chk("pol port", 32'h1, phy_status_polarity);
		bus(1'b0, 8'h68, 16'h0000);
		chk("pol in ctrl", 32'h00000814, rq);
		bus(1'b0, 8'h68, 16'h0000);
		chk("pol cleared", 32'h00000804, rq);
		chk("pol port clr", 32'h0, phy_status_polarity);
		bus(1'b0, 8'hC8, 16'h0000);
		chk("mirror clr", 32'h0, rq & 32'h1000);
		bus(1'b1, 8'hC0, 16'h0001);
		chk("irq cleared", 32'h0, irq);
		bus(1'b0, 8'hC0, 16'h0000);
		chk("status clr", 32'h0, rq & 32'h1);
		// Masked event, then unmasked
		bus(1'b1, 8'hC4, 16'h0000);
		pol_pulse();
		chk("irq masked", 32'h0, irq);
		bus(1'b1, 8'hC4, 16'h0001);
		chk("irq unmask", 32'h1, irq);
		bus(1'b1, 8'hC0, 16'h0001);
		// Unmapped place reads zero and ignores writes
		bus(1'b0, 8'h10, 16'h0000);
		chk("unmapped rd", 32'h0, rq);
		bus(1'b1, 8'h10, 16'hFFFF);
		bus(1'b0, 8'h68, 16'h0000);
		chk("ctrl kept", 32'h00000814, rq);
		// Strap high across a second reset
		serial_strap <= 1'b1;
		do_reset();
		bus(1'b0, 8'h68, 16'h0000);
		chk("strap ctrl", 32'h00008804, rq);
		chk("strap serial", 32'h1, serial_net_if_select);
		chk("pol after rst", 32'h0, phy_status_polarity);
		conclude();
	end
endmodule

`default_nettype wire
